// ===== tpg_tx_pause_gen.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tpg_tx_pause_gen (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [8:0]                tx_pause_req,
    input  wire logic [8:0][15:0]          tx_pause_quanta,
    input  wire logic [8:0][15:0]          tx_pause_refresh,
    input  wire logic [47:0]               global_pause_dest_addr,
    input  wire logic [47:0]               global_pause_src_addr,
    input  wire logic [15:0]               global_pause_ethertype,
    input  wire logic [15:0]               global_pause_opcode,
    input  wire logic [47:0]               priority_pause_dest_addr,
    input  wire logic [47:0]               priority_pause_src_addr,
    input  wire logic [15:0]               priority_pause_ethertype,
    input  wire logic [15:0]               priority_pause_opcode,
    input  wire logic                      tx_resend_pause,
    input  wire logic                      s_valid,
    input  wire tpg_pkg::tpg_beat_t        s_beat,
    output logic                           s_ready_q,
    output logic                           m_valid_q,
    output tpg_pkg::tpg_beat_t             m_beat_q,
    output logic [8:0]                     stat_tx_pause_valid_q,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [31:0]                    reg_rdata_q,
    output logic                           irq_q
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tpg_pkg::tpg_state_t state_q;
    tpg_pkg::tpg_state_t state_d;
    logic [5:0]          idx_q;
    logic [8:0]          sel_q;
    logic                in_frame_q;
    logic [8:0]          status_q;
    logic [8:0]          mask_q;
    logic                en_q;
    logic [8:0]          pend;
    logic [31:0]         crc_q;

    tpg_pkg::tpg_addr_cfg_t gcfg;
    tpg_pkg::tpg_addr_cfg_t pcfg;
    tpg_pkg::tpg_addr_cfg_t cfg;

    assign gcfg = '{global_pause_dest_addr, global_pause_src_addr,
                    global_pause_ethertype, global_pause_opcode};
    assign pcfg = '{priority_pause_dest_addr, priority_pause_src_addr,
                    priority_pause_ethertype, priority_pause_opcode};

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    wire        acc        = s_valid && s_ready_q;
    wire        in_frame_d = acc ? !s_beat.last : in_frame_q;
    wire        busy       = (state_q != tpg_pkg::ST_IDLE);
    wire        frame_done = (state_q == tpg_pkg::ST_FCS) && (idx_q == tpg_pkg::IDX_LAST);
    wire  [8:0] sent_evt   = frame_done ? sel_q : 9'h000;
    // pending bits cleared by this send are not yet visible in pend
    wire  [8:0] pend_eff   = pend & ~sent_evt;
    wire        start      = en_q && (|pend_eff) && !in_frame_d && (!busy || frame_done);
    // global takes precedence, priority classes share one frame
    wire  [8:0] sel_new    = pend_eff[tpg_pkg::GLOBAL_IDX] ? 9'h100 : {1'b0, pend_eff[7:0]};
    wire  [8:0] sel_d      = start ? sel_new : sel_q;
    wire  [5:0] idx_d      = start ? 6'h00 : (busy ? idx_q + 6'h01 : idx_q);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            tpg_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = tpg_pkg::ST_BODY;
                end
            end
            tpg_pkg::ST_BODY: begin
                if (idx_q == tpg_pkg::IDX_FCS - 6'h01) begin
                    state_d = tpg_pkg::ST_FCS;
                end
            end
            tpg_pkg::ST_FCS: begin
                if (frame_done) begin
                    state_d = start ? tpg_pkg::ST_BODY : tpg_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = tpg_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // per-class refresh timers
    // ------------------------------------------------------------
    // one timer per class
    for (genvar i = 0; i < tpg_pkg::NUM_CLASS; i++) begin : g_tmr
        tpg_refresh_timer u_tmr (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .req       (tx_pause_req[i]),
            .interval  (tx_pause_refresh[i]),
            .restart   (tx_resend_pause),
            .sent      (sent_evt[i]),
            .pending_q (pend[i])
        );
    end

    // ------------------------------------------------------------
    // frame byte selection
    // ------------------------------------------------------------
    // global or priority address set, by frame kind
    assign cfg = sel_q[tpg_pkg::GLOBAL_IDX] ? gcfg : pcfg;

    wire [127:0] hdr      = {cfg.dest_addr, cfg.src_addr, cfg.ethertype, cfg.opcode};
    wire [6:0]   hdr_sh   = {~idx_q[3:0], 3'b000};
    wire [7:0]   hdr_byte = hdr[hdr_sh +: 8];
    wire         is_glob  = sel_q[tpg_pkg::GLOBAL_IDX];
    // index 8 is the global quanta
    wire [15:0]  param_w  = is_glob ? tx_pause_quanta[tpg_pkg::GLOBAL_IDX] : {8'h00, sel_q[7:0]};
    wire [5:0]   pq_off   = idx_q - tpg_pkg::IDX_PQUANTA;
    wire [2:0]   pq_cls   = pq_off[3:1];
    wire [15:0]  pq_w     = sel_q[pq_cls] ? tx_pause_quanta[pq_cls] : 16'h0000;
    wire         in_param = (idx_q >= tpg_pkg::IDX_PARAM) && (idx_q < tpg_pkg::IDX_PQUANTA);
    wire         in_pq    = !is_glob && (idx_q >= tpg_pkg::IDX_PQUANTA) && (idx_q < tpg_pkg::IDX_PQ_END);
    // rest of the body up to the check sequence is zero padding
    wire [15:0]  body_w   = in_param ? param_w : (in_pq ? pq_w : 16'h0000);
    wire [7:0]   body_b   = idx_q[0] ? body_w[7:0] : body_w[15:8];
    wire [31:0]  fcs      = ~crc_q;
    wire [7:0]   fcs_byte = fcs[{idx_q[1:0], 3'b000} +: 8];
    wire         in_hdr   = (idx_q < tpg_pkg::IDX_PARAM);
    wire [7:0]   pbyte    = (state_q == tpg_pkg::ST_FCS) ? fcs_byte : (in_hdr ? hdr_byte : body_b);

    // check sequence over the padded body
    tpg_crc32 u_crc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .init    (start),
        .en      (state_q == tpg_pkg::ST_BODY),
        .data    (pbyte),
        .crc_q   (crc_q)
    );

    // ------------------------------------------------------------
    // stream output
    // ------------------------------------------------------------
    // output is never stalled: the mac side takes a beat every valid cycle
    wire                 m_valid_d = busy || acc;
    tpg_pkg::tpg_beat_t  m_beat_d;
    assign m_beat_d = busy ? tpg_pkg::tpg_beat_t'{pbyte, frame_done} : s_beat;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= tpg_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_q <= 6'h00;
        end else begin
            idx_q <= idx_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q <= 9'h000;
        end else begin
            sel_q <= sel_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= in_frame_d;
        end
    end

    // user held off while pending frames go out
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_ready_q <= 1'b0;
        end else begin
            s_ready_q <= (state_d == tpg_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            m_valid_q <= 1'b0;
        end else begin
            m_valid_q <= m_valid_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            m_beat_q <= '0;
        end else begin
            m_beat_q <= m_beat_d;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_tx_pause_valid_q <= 9'h000;
        end else begin
            // bit 8 global, 0 to 7 priority
            stat_tx_pause_valid_q <= sent_evt;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    wire       wr_status = reg_wr && (reg_addr == tpg_pkg::REG_IRQ_STATUS);
    wire       wr_mask   = reg_wr && (reg_addr == tpg_pkg::REG_IRQ_MASK);
    wire       wr_ctrl   = reg_wr && (reg_addr == tpg_pkg::REG_CTRL);
    // set wins over a write-one clear in the same cycle
    wire [8:0] status_d  = (status_q & ~(wr_status ? reg_wdata[8:0] : 9'h000)) | sent_evt;
    wire [8:0] mask_d    = wr_mask ? reg_wdata[8:0] : mask_q;
    wire       en_d      = wr_ctrl ? reg_wdata[tpg_pkg::CTRL_EN_BIT] : en_q;

    wire [31:0] rd_mux =
        (reg_addr == tpg_pkg::REG_IRQ_STATUS) ? {23'h000000, status_q} :
        (reg_addr == tpg_pkg::REG_IRQ_MASK)   ? {23'h000000, mask_q}   :
        (reg_addr == tpg_pkg::REG_PENDING)    ? {23'h000000, pend}     :
        (reg_addr == tpg_pkg::REG_CTRL)       ? {31'h00000000, en_q}   :
                                                32'h00000000;
    wire [31:0] rdata_d = reg_rd ? rd_mux : 32'h00000000;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= 9'h000;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= tpg_pkg::IRQ_MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= tpg_pkg::CTRL_EN_RST;
        end else begin
            en_q <= en_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h00000000;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    // next-state terms so the line follows status without a lag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & mask_d);
        end
    end

endmodule

`default_nettype wire

// ===== tpg_pkg.sv
`default_nettype none

package tpg_pkg;

    // ------------------------------------------------------------
    // classes
    // ------------------------------------------------------------
    localparam int          NUM_CLASS     = 9;
    localparam int          GLOBAL_IDX    = 8;

    // ------------------------------------------------------------
    // pause frame byte layout
    // ------------------------------------------------------------
    localparam logic [5:0]  IDX_PARAM     = 6'h10;
    localparam logic [5:0]  IDX_PQUANTA   = 6'h12;
    localparam logic [5:0]  IDX_PQ_END    = 6'h22;
    localparam logic [5:0]  IDX_FCS       = 6'h3c;
    localparam logic [5:0]  IDX_LAST      = 6'h3f;

    // ------------------------------------------------------------
    // frame check sequence
    // ------------------------------------------------------------
    localparam logic [31:0] CRC_INIT      = 32'hffffffff;
    localparam logic [31:0] CRC_POLY      = 32'hedb88320;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_IRQ_STATUS = 8'h00;
    localparam logic [7:0]  REG_IRQ_MASK   = 8'h04;
    localparam logic [7:0]  REG_PENDING    = 8'h08;
    localparam logic [7:0]  REG_CTRL       = 8'h0c;
    localparam logic [8:0]  IRQ_MASK_RST   = 9'h000;
    localparam logic        CTRL_EN_RST    = 1'b1;
    localparam int          CTRL_EN_BIT    = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [47:0] dest_addr;
        logic [47:0] src_addr;
        logic [15:0] ethertype;
        logic [15:0] opcode;
    } tpg_addr_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } tpg_beat_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BODY = 2'b01,
        ST_FCS  = 2'b11
    } tpg_state_t;

endpackage

`default_nettype wire

// ===== tpg_crc32.sv
`timescale 1ns/1ps
`default_nettype none

module tpg_crc32 (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        init,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [31:0] crc_q
);

    logic [31:0] crc_d;

    // ------------------------------------------------------------
    // reflected byte update, lsb first
    // ------------------------------------------------------------
    always_comb begin
        crc_d = crc_q;
        for (int b = 0; b < 8; b++) begin
            if (crc_d[0] ^ data[b]) begin
                crc_d = (crc_d >> 1) ^ tpg_pkg::CRC_POLY;
            end else begin
                crc_d = crc_d >> 1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            crc_q <= tpg_pkg::CRC_INIT;
        end else if (init) begin
            crc_q <= tpg_pkg::CRC_INIT;
        end else if (en) begin
            crc_q <= crc_d;
        end
    end

endmodule

`default_nettype wire

// ===== tpg_refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none

module tpg_refresh_timer (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        req,
    input  wire logic [15:0] interval,
    input  wire logic        restart,
    input  wire logic        sent,
    output logic             pending_q
);

    logic [15:0] cnt_q;
    logic        req_prev_q;

    wire  [15:0] cnt_inc = cnt_q + 16'h0001;
    // an interval of zero disables repetition
    wire         expire  = req && (interval != 16'h0000) && (cnt_inc >= interval);
    wire         cnt_clr = !req || restart || sent || expire;
    // set wins over the clear by a send
    wire         set     = (req && !req_prev_q) || expire || (restart && req);
    wire         pend_d  = set || (pending_q && !sent);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q      <= 16'h0000;
            req_prev_q <= 1'b0;
            pending_q  <= 1'b0;
        end else begin
            cnt_q      <= cnt_clr ? 16'h0000 : cnt_inc;
            req_prev_q <= req;
            pending_q  <= pend_d;
        end
    end

endmodule

`default_nettype wire

// ===== tpg_tx_pause_gen_props.sv
`timescale 1ns/1ps
`default_nettype none

module tpg_tx_pause_gen_props (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic [8:0]         tx_pause_req,
    input  wire logic               tx_resend_pause,
    input  wire logic               s_valid,
    input  wire tpg_pkg::tpg_beat_t s_beat,
    input  wire logic               s_ready_q,
    input  wire logic               m_valid_q,
    input  wire tpg_pkg::tpg_beat_t m_beat_q,
    input  wire logic [8:0]         stat_tx_pause_valid_q,
    input  wire logic               reg_rd,
    input  wire logic [31:0]        reg_rdata_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // beats since the last end of frame
    // ------------------------------------------------------------
    logic [6:0] beat_cnt_q;
    logic [6:0] beat_cnt_d;
    assign beat_cnt_d = (m_valid_q && m_beat_q.last) ? 7'h00 : beat_cnt_q + {6'h00, m_valid_q};
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            beat_cnt_q <= 7'h00;
        end else begin
            beat_cnt_q <= beat_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    // bound covers one user frame in flight plus two pause frames
    sequence glob_sent_s;
        ##[1:400] stat_tx_pause_valid_q[8];
    endsequence
    sequence prio_sent_s;
        ##[1:400] (stat_tx_pause_valid_q[7:0] != 8'h00);
    endsequence

    glob_req_a: assert property ($rose(tx_pause_req[8]) |-> glob_sent_s)
        else $error("global request not sent");
    prio_req_a: assert property ((tx_pause_req[7:0] & ~$past(tx_pause_req[7:0])) != 8'h00 |-> prio_sent_s)
        else $error("priority request not sent");
    resend_sent_a: assert property (tx_resend_pause && tx_pause_req[7:0] != 8'h00 |-> prio_sent_s)
        else $error("resend did not send");
    stat_pulse_a: assert property (stat_tx_pause_valid_q != 9'h000 |=> stat_tx_pause_valid_q == 9'h000)
        else $error("sent flag longer than one cycle");
    stat_kind_a: assert property (!(stat_tx_pause_valid_q[8] && stat_tx_pause_valid_q[7:0] != 8'h00))
        else $error("global and priority flagged together");
    frame_len_a: assert property (stat_tx_pause_valid_q != 9'h000 |-> m_valid_q && m_beat_q.last
                                  && beat_cnt_q == 7'h3f && !$past(s_ready_q))
        else $error("pause frame not 64 bytes");
    pass_through_a: assert property (s_valid && s_ready_q |=> m_valid_q && m_beat_q == $past(s_beat))
        else $error("user beat not passed on");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h00000000)
        else $error("read data outside read cycle");
endmodule

bind tpg_tx_pause_gen tpg_tx_pause_gen_props chk_u (.clk, .sys_rst, .tx_pause_req, .tx_resend_pause, .s_valid,
    .s_beat, .s_ready_q, .m_valid_q, .m_beat_q, .stat_tx_pause_valid_q, .reg_rd, .reg_rdata_q);

`default_nettype wire

// ===== tpg_flow_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// user flow-control side
// ------------------------------------------------------------
module tpg_flow_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [8:0] cmd_req,
    input  wire logic       cmd_resend,
    output logic      [8:0] tx_pause_req,
    output logic            tx_resend_pause
);
    logic cmd_resend_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_pause_req    <= 9'h000;
            cmd_resend_q    <= 1'b0;
            tx_resend_pause <= 1'b0;
        end else begin
            tx_pause_req    <= cmd_req;
            cmd_resend_q    <= cmd_resend;
            tx_resend_pause <= cmd_resend && !cmd_resend_q;
        end
    end
endmodule

`default_nettype wire

// ===== tb_tpg_tx_pause_gen.sv
`timescale 1ns/1ps
`default_nettype none

module tb_tpg_tx_pause_gen;
    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic [8:0]         cmd_req = 9'h000;
    logic               cmd_resend = 1'b0;
    logic [8:0]         req;
    logic               resend;
    logic [8:0][15:0]   quanta;
    logic [8:0][15:0]   refresh;
    logic [127:0]       ghdr = 128'h0a1b2c3d4e5f021122334455_8808_0001;
    logic [127:0]       phdr = 128'h0c0d0e0f1011067788990aab_88a8_0101;
    logic               s_valid = 1'b0;
    tpg_pkg::tpg_beat_t s_beat = '0;
    logic               s_ready_q;
    logic               m_valid_q;
    tpg_pkg::tpg_beat_t m_beat_q;
    logic [8:0]         stat;
    logic [7:0]         reg_addr = 8'h00;
    logic [31:0]        reg_wdata = 32'h0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [31:0]        reg_rdata_q;
    logic               irq_q;
    logic [31:0]        rd;
    logic [7:0]         cap[$];
    logic [7:0]         got[$];
    logic [8:0]         got_stat;
    int                 num_errors = 0;
    int                 cmp_count = 0;
    int                 nfrm = 0;
    int                 cyc = 0;
    int                 t_end;
    int                 t0;

    always #12.5 clk = ~clk;

    tpg_flow_model fc_u (.clk(clk), .sys_rst(sys_rst), .cmd_req(cmd_req), .cmd_resend(cmd_resend),
        .tx_pause_req(req), .tx_resend_pause(resend));
    tpg_tx_pause_gen dut_u (.clk(clk), .sys_rst(sys_rst), .tx_pause_req(req), .tx_pause_quanta(quanta),
        .tx_pause_refresh(refresh), .global_pause_dest_addr(ghdr[127:80]), .global_pause_src_addr(ghdr[79:32]),
        .global_pause_ethertype(ghdr[31:16]), .global_pause_opcode(ghdr[15:0]),
        .priority_pause_dest_addr(phdr[127:80]), .priority_pause_src_addr(phdr[79:32]),
        .priority_pause_ethertype(phdr[31:16]), .priority_pause_opcode(phdr[15:0]), .tx_resend_pause(resend),
        .s_valid(s_valid), .s_beat(s_beat), .s_ready_q(s_ready_q), .m_valid_q(m_valid_q), .m_beat_q(m_beat_q),
        .stat_tx_pause_valid_q(stat), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));

    // ------------------------------------------------------------
    // output capture, off the sampling edge
    // ------------------------------------------------------------
    always @(negedge clk) begin
        cyc++;
        if (m_valid_q === 1'b1) begin
            cap.push_back(m_beat_q.data);
            if (m_beat_q.last === 1'b1) begin
                got = cap;
                cap = {};
                got_stat = stat;
                t_end = cyc;
                nfrm++;
            end
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_rd_t(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata_q;
    endtask

    task automatic wait_frames(input int n);
        for (int t = 0; t < 600 && nfrm < n; t++) @(posedge clk);
        check("frame_count", 32'(nfrm), 32'(n));
        #13;
    endtask

    // expected pause frame, check sequence worked out byte by byte
    task automatic expect_frame(input logic glob, input logic [7:0] cls);
        logic [7:0]  e[64];
        logic [31:0] c;
        e = '{default: 8'h00};
        for (int i = 0; i < 16; i++) e[i] = glob ? ghdr[127-8*i -: 8] : phdr[127-8*i -: 8];
        e[16] = glob ? quanta[8][15:8] : 8'h00;
        e[17] = glob ? quanta[8][7:0] : cls;
        for (int k = 0; k < 8; k++) {e[18+2*k], e[19+2*k]} = (!glob && cls[k]) ? quanta[k] : 16'h0000;
        c = 32'hffffffff;
        for (int i = 0; i < 60; i++) begin
            c = c ^ {24'h000000, e[i]};
            for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ tpg_pkg::CRC_POLY) : (c >> 1);
        end
        c = ~c;
        for (int i = 0; i < 4; i++) e[60+i] = c[8*i +: 8];
        check("frame_len", 32'(got.size()), 32'd64);
        for (int i = 0; i < 64 && i < got.size(); i++) check("frame_byte", {24'h0, got[i]}, {24'h0, e[i]});
        check("sent_flag", {23'h0, got_stat}, glob ? 32'h100 : {24'h0, cls});
    endtask

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 9; i++) quanta[i] = 16'h1000 + 16'(i) * 16'h0111;
        refresh = '0;
        refresh[3] = 16'h00c8;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("ready_after_reset", {31'h0, s_ready_q}, 32'h1);
        reg_rd_t(tpg_pkg::REG_IRQ_MASK);
        check("mask_reset", rd, 32'h0);
        reg_rd_t(tpg_pkg::REG_CTRL);
        check("ctrl_reset", rd, 32'h1);
        reg_rd_t(8'h40);
        check("unmapped_read", rd, 32'h0);
        // global frame, sticky status, interrupt raise and clear
        reg_wr_t(tpg_pkg::REG_IRQ_MASK, 32'h1ff);
        cmd_req <= 9'h100;
        wait_frames(1);
        expect_frame(1'b1, 8'h00);
        repeat (3) @(posedge clk);
        #1 check("irq_raised", {31'h0, irq_q}, 32'h1);
        reg_rd_t(tpg_pkg::REG_IRQ_STATUS);
        check("status", rd, 32'h100);
        reg_wr_t(tpg_pkg::REG_IRQ_STATUS, 32'h100);
        repeat (2) @(posedge clk);
        #1 check("irq_cleared", {31'h0, irq_q}, 32'h0);
        cmd_req <= 9'h000;
        // disabled: requests stay pending, then coalesce into one frame
        reg_wr_t(tpg_pkg::REG_CTRL, 32'h0);
        cmd_req <= 9'h021;
        repeat (40) @(posedge clk);
        check("no_frame_disabled", 32'(nfrm), 32'd1);
        reg_rd_t(tpg_pkg::REG_PENDING);
        check("pending", rd, 32'h021);
        reg_wr_t(tpg_pkg::REG_CTRL, 32'h1);
        wait_frames(2);
        expect_frame(1'b0, 8'h21);
        // held request repeats on its interval; resend restarts the count
        cmd_req <= 9'h008;
        wait_frames(3);
        t0 = t_end;
        wait_frames(4);
        check("refresh_gap", {31'h0, (t_end - t0 >= 200) && (t_end - t0 <= 280)}, 32'h1);
        repeat (50) @(posedge clk);
        cmd_resend <= 1'b1;
        @(posedge clk);
        cmd_resend <= 1'b0;
        t0 = cyc;
        wait_frames(5);
        check("resend_prompt", {31'h0, t_end - t0 < 80}, 32'h1);
        expect_frame(1'b0, 8'h08);
        t0 = t_end;
        wait_frames(6);
        check("restart_gap", {31'h0, t_end - t0 >= 200}, 32'h1);
        cmd_req <= 9'h000;
        repeat (400) @(posedge clk);
        check("repeat_stops", 32'(nfrm), 32'd6);
        // request raised inside a user frame waits for its end
        for (int i = 0; i < 10; i++) begin
            s_valid <= 1'b1;
            s_beat  <= '{data: 8'(i + 1), last: i == 9};
            if (i == 3) cmd_req <= 9'h100;
            for (int t = 0; t < 100; t++) begin
                @(posedge clk);
                if (s_ready_q === 1'b1) break;
            end
        end
        s_valid <= 1'b0;
        wait_frames(7);
        check("user_frame_len", 32'(got.size()), 32'd10);
        for (int i = 0; i < 10 && i < got.size(); i++) check("user_byte", {24'h0, got[i]}, 32'(i + 1));
        wait_frames(8);
        expect_frame(1'b1, 8'h00);
        cmd_req <= 9'h000;
        repeat (10) @(posedge clk);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule

`default_nettype wire
